// ### verilog/pci_bus_defs.svh
// Constants shared by both ends of the multiplexed bus link.
// Functional notes
// - Master drives address during first frame clock.
// - Master drives write data; target drives read data.
// - Master drives command during first frame clock.
// - Master drives byte enables in data phases.
// - Target asserts decode on address hit.
// - Frame starts transaction; release marks last phase.
// - Internal arbiter drives both grant outputs.
// - External arbiter: grant 0 input, grant 1 high.
// - Satellite: grant 1 becomes EEPROM chip select.
// - Master asserts initiator ready for data phase.
// - Lock low marks exclusive access in progress.
// - Parity line is even parity over data.
// - Master drives parity on address/write; target on read.
// - Receiver asserts parity error two clocks later.
// - All bus activity follows bus clock edges; the code drives satellite grant 1 and request 1 on ref_clk edges.
// - Internal arbiter: request lines are agent inputs.
// - External arbiter: request 0 out, request 1 high.
// - Satellite: request 1 becomes config select input.
`ifndef PCI_BUS_DEFS_SVH
`define PCI_BUS_DEFS_SVH

// ****************************************
// Timing
// ****************************************
`define PCI_BUS_CLK_PERIOD_NS 320
`define PCI_PERR_DELAY        2
`define PCI_DEVSEL_WAIT       3'h5

// ****************************************
// Commands and reset values
// ****************************************
`define PCI_CMD_WRITE_BIT     0
`define PCI_CMD_CFG_READ      4'hA
`define PCI_CMD_CFG_WRITE     4'hB
`define PCI_GNT_NONE          2'h3

`endif

// ### verilog/pci_bus_pkg.sv
// Types and helpers shared by both ends of the bus link.
package pci_bus_pkg;

   typedef enum logic [1:0] {
      ARB_INTERNAL  = 2'h0,
      ARB_EXTERNAL  = 2'h1,
      ARB_SATELLITE = 2'h2
   } arbMode_t;

   typedef enum logic [3:0] {
      M_IDLE = 4'h1,
      M_ADDR = 4'h2,
      M_DATA = 4'h4,
      M_TURN = 4'h8
   } mstState_t;

   typedef enum logic [2:0] {
      T_IDLE = 3'h1,
      T_DATA = 3'h2,
      T_TURN = 3'h4
   } tgtState_t;

   typedef struct packed {
      logic [31:0] ad;
      logic [3:0]  cbe;
      logic        par;
      logic        frame;
      logic        irdy;
      logic        devsel;
      logic        lock;
      logic        perr;
      logic [1:0]  req;
      logic [1:0]  gnt;
   } busPins_t;

   typedef struct packed {
      busPins_t val;
      busPins_t oe;
   } busDrive_t;

   function automatic logic evenPar(input logic [31:0] v);
      return ^v;
   endfunction : evenPar

   // Undriven bits float high through the pull-ups.
   function automatic busPins_t resolve(input busDrive_t a, input busDrive_t b);
      return busPins_t'((a.oe & a.val) | (~a.oe & b.oe & b.val) | (~a.oe & ~b.oe));
   endfunction : resolve

endpackage : pci_bus_pkg

// ### verilog/pci_link.sv
// Interface joining the device end and the far end of the bus.
`timescale 1ns/1ps
interface pci_link (
   input wire logic busClock
);
   import pci_bus_pkg::*;

   busDrive_t devDrv;
   busDrive_t farDrv;
   busPins_t  pins;

   assign pins = resolve(devDrv, farDrv);

   modport dev (output devDrv, input pins, input busClock);
   modport far (output farDrv, input pins, input busClock);
endinterface : pci_link

// ### verilog/pci_bus_pin_signalling.sv
// Device end of the bus: master, target, parity and mode-dependent arbitration.
`timescale 1ns/1ps
`include "pci_bus_defs.svh"
module pci_bus_pin_signalling #(
   parameter logic [31:0] TGT_BASE = 32'h1000_0000,
   parameter logic [31:0] TGT_MASK = 32'hFFFF_0000
) (
   // Clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  sys_rst,
   // Bus link
   pci_link.dev                       link,
   // Arbitration strap
   input  wire pci_bus_pkg::arbMode_t arbMode,
   // Master request
   input  wire logic                  mstStart,
   input  wire logic [31:0]           mstAddr,
   input  wire logic [3:0]            mstCmd,
   input  wire logic [3:0]            mstByteEnL,
   input  wire logic [31:0]           mstWdata,
   output logic                       mstBusy,
   output logic                       mstDone,
   output logic                       mstAbort,
   // Target side
   input  wire logic [31:0]           tgtRdata,
   output logic                       tgtWrite,
   output logic [31:0]                tgtAddr,
   output logic [3:0]                 tgtByteEnL,
   // Received data and status
   output logic [31:0]                rxData,
   output logic                       perrSeen,
   output logic                       lockActive,
   output logic                       configSel,
   // Serial EEPROM select
   input  wire logic                  eepromChipSelect
);
   import pci_bus_pkg::*;

   typedef struct packed {
      logic [46:0] sync1;
      logic [46:0] sync2;
      logic        clkPrev;
      logic        frameHi;
      logic        modeSet;
      arbMode_t    mode;
      mstState_t   mst;
      tgtState_t   tgt;
      logic [2:0]  waitCnt;
      logic        mstPend;
      logic [31:0] mAddr;
      logic [31:0] mData;
      logic [3:0]  mCmd;
      logic [3:0]  mBe;
      logic        tWr;
      logic [31:0] tAddr;
      logic [3:0]  tBe;
      logic [1:0]  perrPipe;
      busDrive_t   drv;
      logic        mstDone;
      logic        mstAbort;
      logic        tgtWrite;
      logic        perrSeen;
      logic        lockActive;
      logic        configSel;
      logic [31:0] rxData;
   } state_t;

   state_t   q;
   state_t   n;
   busPins_t b;
   logic     busEdge;
   logic     busIdle;
   logic     own;
   logic     hit;

   // ****************************************
   // Sampled bus view
   // ****************************************
   // The bus clock is only seen through the synchroniser; its edges are found here.
   assign b       = busPins_t'(q.sync2[45:0]);
   assign busEdge = q.sync2[46] & ~q.clkPrev;
   assign busIdle = b.frame & b.irdy;
   assign own     = (q.mode == ARB_INTERNAL) ? (q.drv.val.gnt == `PCI_GNT_NONE) : ~b.gnt[0];
   assign hit     = ((b.ad & TGT_MASK) == TGT_BASE)
                  | ((q.mode == ARB_SATELLITE) & b.req[1]
                     & ((b.cbe == `PCI_CMD_CFG_READ) | (b.cbe == `PCI_CMD_CFG_WRITE)));

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      n          = q;
      n.sync1    = {link.busClock, link.pins};
      n.sync2    = q.sync1;
      n.clkPrev  = q.sync2[46];
      n.mstDone  = 1'b0;
      n.mstAbort = 1'b0;
      n.tgtWrite = 1'b0;
      n.perrSeen = 1'b0;

      // The strap is taken once after reset so the mode cannot move under traffic.
      if (!q.modeSet) begin
         n.mode    = arbMode;
         n.modeSet = 1'b1;
      end

      // Sideband direction follows the mode.
      case (q.mode)
         ARB_INTERNAL: begin
            n.drv.oe.req = 2'h0;
            n.drv.oe.gnt = 2'h3;
         end
         ARB_EXTERNAL: begin
            n.drv.oe.req      = 2'h3;
            n.drv.val.req[1]  = 1'b1;
            // Grant 1 is held high by this end rather than left to the pull-up.
            n.drv.oe.gnt      = 2'h2;
            n.drv.val.gnt     = `PCI_GNT_NONE;
         end
         default: begin
            n.drv.oe.req      = 2'h1;
            n.drv.val.req[1]  = 1'b1;
            n.drv.oe.gnt      = 2'h2;
            n.drv.val.gnt[1]  = eepromChipSelect;
            n.drv.val.gnt[0]  = 1'b1;
         end
      endcase

      n.lockActive = ~b.lock;
      n.configSel  = (q.mode == ARB_SATELLITE) & b.req[1];

      if (mstStart && !q.mstPend) begin
         n.mstPend = 1'b1;
         n.mAddr   = mstAddr;
         n.mCmd    = mstCmd;
         n.mBe     = mstByteEnL;
         n.mData   = mstWdata;
      end

      if (busEdge) begin
         n.frameHi = b.frame;

         // Parity error goes out two bus clocks after the data edge.
         n.perrPipe     = {q.perrPipe[0], 1'b0};
         n.drv.oe.perr  = q.perrPipe[1];
         n.drv.val.perr = ~q.perrPipe[1];

         // Internal arbiter: fixed priority, grant held until the request drops.
         if (q.mode == ARB_INTERNAL) begin
            if (q.drv.val.gnt != `PCI_GNT_NONE) begin
               if ((~b.req & ~q.drv.val.gnt) == 2'h0) begin
                  n.drv.val.gnt = `PCI_GNT_NONE;
               end
            end else if (busIdle && q.mst == M_IDLE && !q.mstPend) begin
               if (!b.req[0]) begin
                  n.drv.val.gnt = 2'h2;
               end else if (!b.req[1]) begin
                  n.drv.val.gnt = 2'h1;
               end
            end
         end else begin
            n.drv.val.req[0] = ~(q.mstPend && q.mst == M_IDLE);
         end

         // ****************************************
         // Master engine, single data phase
         // ****************************************
         case (q.mst)
            M_IDLE: begin
               if (q.mstPend && busIdle && own && q.tgt == T_IDLE) begin
                  n.drv.oe.frame  = 1'b1;
                  n.drv.val.frame = 1'b0;
                  n.drv.oe.irdy   = 1'b1;
                  n.drv.val.irdy  = 1'b1;
                  n.drv.oe.ad     = '1;
                  n.drv.val.ad    = q.mAddr;
                  n.drv.oe.cbe    = '1;
                  n.drv.val.cbe   = q.mCmd;
                  n.drv.oe.par    = 1'b1;
                  n.drv.val.par   = evenPar(q.mAddr);
                  n.mst           = M_ADDR;
               end
            end
            M_ADDR: begin
               n.drv.val.frame = 1'b1;
               n.drv.val.irdy  = 1'b0;
               n.drv.val.cbe   = q.mBe;
               n.waitCnt       = 3'h0;
               if (q.mCmd[`PCI_CMD_WRITE_BIT]) begin
                  n.drv.val.ad  = q.mData;
                  n.drv.val.par = evenPar(q.mData);
               end else begin
                  n.drv.oe.ad   = '0;
                  n.drv.oe.par  = 1'b0;
               end
               n.mst = M_DATA;
            end
            M_DATA: begin
               if (!b.devsel && !b.irdy) begin
                  n.mstDone = 1'b1;
                  if (!q.mCmd[`PCI_CMD_WRITE_BIT]) begin
                     n.rxData = b.ad;
                     if (evenPar(b.ad) != b.par) begin
                        n.perrPipe[0] = 1'b1;
                        n.perrSeen    = 1'b1;
                     end
                  end
               end else if (q.waitCnt == `PCI_DEVSEL_WAIT) begin
                  n.mstAbort = 1'b1;
               end else begin
                  n.waitCnt = q.waitCnt + 3'h1;
               end
               if (n.mstDone || n.mstAbort) begin
                  n.drv.val.irdy = 1'b1;
                  n.drv.oe.ad    = '0;
                  n.drv.oe.par   = 1'b0;
                  n.mstPend      = 1'b0;
                  n.mst          = M_TURN;
               end
            end
            default: begin
               n.drv.oe.frame = 1'b0;
               n.drv.oe.irdy  = 1'b0;
               n.drv.oe.cbe   = '0;
               n.mst          = M_IDLE;
            end
         endcase

         // ****************************************
         // Target engine
         // ****************************************
         case (q.tgt)
            T_IDLE: begin
               if (!b.frame && q.frameHi && q.mst == M_IDLE && hit) begin
                  n.tAddr          = b.ad;
                  n.tWr            = b.cbe[`PCI_CMD_WRITE_BIT];
                  n.drv.oe.devsel  = 1'b1;
                  n.drv.val.devsel = 1'b0;
                  if (!b.cbe[`PCI_CMD_WRITE_BIT]) begin
                     n.drv.oe.ad   = '1;
                     n.drv.val.ad  = tgtRdata;
                     n.drv.oe.par  = 1'b1;
                     n.drv.val.par = evenPar(tgtRdata);
                  end
                  n.tgt = T_DATA;
               end
            end
            T_DATA: begin
               if (!b.irdy) begin
                  if (q.tWr) begin
                     n.rxData   = b.ad;
                     n.tBe      = b.cbe;
                     n.tgtWrite = 1'b1;
                     if (evenPar(b.ad) != b.par) begin
                        n.perrPipe[0] = 1'b1;
                        n.perrSeen    = 1'b1;
                     end
                  end
                  n.drv.val.devsel = 1'b1;
                  n.drv.oe.ad      = '0;
                  n.drv.oe.par     = 1'b0;
                  n.tgt            = T_TURN;
               end
            end
            default: begin
               n.drv.oe.devsel = 1'b0;
               n.tgt           = T_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         q         <= '0;
         q.sync1   <= '1;
         q.sync2   <= '1;
         q.clkPrev <= 1'b1;
         q.frameHi <= 1'b1;
         q.mst     <= M_IDLE;
         q.tgt     <= T_IDLE;
         q.drv.val <= '1;
      end else begin
         q <= n;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign link.devDrv = q.drv;
   assign mstBusy     = q.mstPend;
   assign mstDone     = q.mstDone;
   assign mstAbort    = q.mstAbort;
   assign tgtWrite    = q.tgtWrite;
   assign tgtAddr     = q.tAddr;
   assign tgtByteEnL  = q.tBe;
   assign rxData      = q.rxData;
   assign perrSeen    = q.perrSeen;
   assign lockActive  = q.lockActive;
   assign configSel   = q.configSel;

endmodule : pci_bus_pin_signalling

// ### verilog/pci_bus_far_agent.sv
// Far end of the bus: another agent that masters, answers and arbitrates.
`timescale 1ns/1ps
`include "pci_bus_defs.svh"
module pci_bus_far_agent #(
   parameter logic [31:0] TGT_BASE = 32'h2000_0000,
   parameter logic [31:0] TGT_MASK = 32'hFFFF_0000
) (
   // Clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  sys_rst,
   // Bus link
   pci_link.far                       link,
   // Arbitration strap
   input  wire pci_bus_pkg::arbMode_t arbMode,
   // Master request
   input  wire logic                  mstStart,
   input  wire logic                  mstLock,
   input  wire logic [31:0]           mstAddr,
   input  wire logic [3:0]            mstCmd,
   input  wire logic [3:0]            mstByteEnL,
   input  wire logic [31:0]           mstWdata,
   output logic                       mstBusy,
   output logic                       mstDone,
   output logic                       mstAbort,
   // Target side and status
   input  wire logic [31:0]           tgtRdata,
   output logic                       tgtWrite,
   output logic [31:0]                rxData,
   output logic                       perrSeen,
   // Satellite sideband
   input  wire logic                  configSelect,
   output logic                       eepromSelSeen
);
   import pci_bus_pkg::*;

   typedef struct packed {
      logic [46:0] sync1;
      logic [46:0] sync2;
      logic        clkPrev;
      logic        frameHi;
      logic        modeSet;
      arbMode_t    mode;
      mstState_t   mst;
      tgtState_t   tgt;
      logic [2:0]  waitCnt;
      logic        mstPend;
      logic        mLock;
      logic [31:0] mAddr;
      logic [31:0] mData;
      logic [3:0]  mCmd;
      logic [3:0]  mBe;
      logic        tWr;
      logic [1:0]  perrPipe;
      busDrive_t   drv;
      logic        mstDone;
      logic        mstAbort;
      logic        tgtWrite;
      logic        perrSeen;
      logic        eeSel;
      logic [31:0] rxData;
   } state_t;

   state_t   q;
   state_t   n;
   busPins_t b;
   logic     busEdge;
   logic     busIdle;
   logic     internal;
   logic     done;

   assign b        = busPins_t'(q.sync2[45:0]);
   assign busEdge  = q.sync2[46] & ~q.clkPrev;
   assign busIdle  = b.frame & b.irdy;
   assign internal = (q.mode == ARB_INTERNAL);
   assign done     = !b.devsel && !b.irdy;

   always_comb begin
      n          = q;
      n.sync1    = {link.busClock, link.pins};
      n.sync2    = q.sync1;
      n.clkPrev  = q.sync2[46];
      n.mstDone  = 1'b0;
      n.mstAbort = 1'b0;
      n.tgtWrite = 1'b0;
      n.perrSeen = 1'b0;
      if (!q.modeSet) begin
         n.mode    = arbMode;
         n.modeSet = 1'b1;
      end
      // Internal: this agent requests on line 0. Otherwise it is the arbiter on grant 0.
      n.drv.oe.req     = internal ? 2'h1 : ((q.mode == ARB_SATELLITE) ? 2'h2 : 2'h0);
      n.drv.oe.gnt     = internal ? 2'h0 : 2'h1;
      n.drv.val.req[1] = configSelect | (q.mode != ARB_SATELLITE);
      n.eeSel          = (q.mode == ARB_SATELLITE) & b.gnt[1];
      if (mstStart && !q.mstPend) begin
         n.mstPend = 1'b1;
         n.mLock   = mstLock;
         n.mAddr   = mstAddr;
         n.mCmd    = mstCmd;
         n.mBe     = mstByteEnL;
         n.mData   = mstWdata;
      end
      if (busEdge) begin
         n.frameHi      = b.frame;
         n.perrPipe     = {q.perrPipe[0], 1'b0};
         n.drv.oe.perr  = q.perrPipe[1];
         n.drv.val.perr = ~q.perrPipe[1];
         if (internal) begin
            n.drv.val.req[0] = ~(q.mstPend && q.mst == M_IDLE);
         end else if (!q.drv.val.gnt[0]) begin
            n.drv.val.gnt[0] = ~(!b.req[0]);
         end else if (busIdle && !b.req[0] && q.mst == M_IDLE && !q.mstPend) begin
            n.drv.val.gnt[0] = 1'b0;
         end
         case (q.mst)
            M_IDLE: begin
               if (q.mstPend && busIdle && q.tgt == T_IDLE
                   && (internal ? !b.gnt[0] : q.drv.val.gnt[0])) begin
                  n.drv.oe.frame  = 1'b1;
                  n.drv.val.frame = 1'b0;
                  n.drv.oe.irdy   = 1'b1;
                  n.drv.val.irdy  = 1'b1;
                  n.drv.oe.lock   = q.mLock;
                  n.drv.val.lock  = ~q.mLock;
                  n.drv.oe.ad     = '1;
                  n.drv.val.ad    = q.mAddr;
                  n.drv.oe.cbe    = '1;
                  n.drv.val.cbe   = q.mCmd;
                  n.drv.oe.par    = 1'b1;
                  n.drv.val.par   = evenPar(q.mAddr);
                  n.mst           = M_ADDR;
               end
            end
            M_ADDR: begin
               n.drv.val.frame = 1'b1;
               n.drv.val.irdy  = 1'b0;
               n.drv.val.cbe   = q.mBe;
               n.drv.val.ad    = q.mData;
               n.drv.val.par   = evenPar(q.mData);
               n.drv.oe.ad     = {32{q.mCmd[`PCI_CMD_WRITE_BIT]}};
               n.drv.oe.par    = q.mCmd[`PCI_CMD_WRITE_BIT];
               n.waitCnt       = 3'h0;
               n.mst           = M_DATA;
            end
            M_DATA: begin
               n.waitCnt  = q.waitCnt + 3'h1;
               n.mstAbort = !done && (q.waitCnt == `PCI_DEVSEL_WAIT);
               n.mstDone  = done;
               if (done && !q.mCmd[`PCI_CMD_WRITE_BIT]) begin
                  n.rxData      = b.ad;
                  n.perrPipe[0] = evenPar(b.ad) != b.par;
                  n.perrSeen    = evenPar(b.ad) != b.par;
               end
               if (n.mstDone || n.mstAbort) begin
                  n.drv.val.irdy = 1'b1;
                  n.drv.val.lock = 1'b1;
                  n.drv.oe.ad    = '0;
                  n.drv.oe.par   = 1'b0;
                  n.mstPend      = 1'b0;
                  n.mst          = M_TURN;
               end
            end
            default: begin
               n.drv.oe.frame = 1'b0;
               n.drv.oe.irdy  = 1'b0;
               n.drv.oe.lock  = 1'b0;
               n.drv.oe.cbe   = '0;
               n.mst          = M_IDLE;
            end
         endcase
         case (q.tgt)
            T_IDLE: begin
               if (!b.frame && q.frameHi && q.mst == M_IDLE
                   && ((b.ad & TGT_MASK) == TGT_BASE)) begin
                  n.tWr            = b.cbe[`PCI_CMD_WRITE_BIT];
                  n.drv.oe.devsel  = 1'b1;
                  n.drv.val.devsel = 1'b0;
                  n.drv.oe.ad      = {32{~b.cbe[`PCI_CMD_WRITE_BIT]}};
                  n.drv.val.ad     = tgtRdata;
                  n.drv.oe.par     = ~b.cbe[`PCI_CMD_WRITE_BIT];
                  n.drv.val.par    = evenPar(tgtRdata);
                  n.tgt            = T_DATA;
               end
            end
            T_DATA: begin
               if (!b.irdy) begin
                  if (q.tWr) begin
                     n.rxData      = b.ad;
                     n.tgtWrite    = 1'b1;
                     n.perrPipe[0] = evenPar(b.ad) != b.par;
                     n.perrSeen    = evenPar(b.ad) != b.par;
                  end
                  n.drv.val.devsel = 1'b1;
                  n.drv.oe.ad      = '0;
                  n.drv.oe.par     = 1'b0;
                  n.tgt            = T_TURN;
               end
            end
            default: begin
               n.drv.oe.devsel = 1'b0;
               n.tgt           = T_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         q         <= '0;
         q.sync1   <= '1;
         q.sync2   <= '1;
         q.clkPrev <= 1'b1;
         q.frameHi <= 1'b1;
         q.mst     <= M_IDLE;
         q.tgt     <= T_IDLE;
         q.drv.val <= '1;
      end else begin
         q <= n;
      end
   end

   assign link.farDrv   = q.drv;
   assign mstBusy       = q.mstPend;
   assign mstDone       = q.mstDone;
   assign mstAbort      = q.mstAbort;
   assign tgtWrite      = q.tgtWrite;
   assign rxData        = q.rxData;
   assign perrSeen      = q.perrSeen;
   assign eepromSelSeen = q.eeSel;

endmodule : pci_bus_far_agent

// ### tb/pci_bus_checker.sv
// Concurrent checks on the pins shared by the two bus ends.
`timescale 1ns/1ps
module pci_bus_checker (
   input wire logic                   ref_clk,
   input wire logic                   sys_rst,
   input wire pci_bus_pkg::busDrive_t devDrv,
   input wire pci_bus_pkg::busDrive_t farDrv,
   input wire pci_bus_pkg::busPins_t  pins
);
   import pci_bus_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   property p_par; devDrv.oe.par |-> devDrv.val.par == ^devDrv.val.ad; endproperty
   a_par: assert property (p_par) else $error("odd parity");
   property p_own; !(|(devDrv.oe.ad & farDrv.oe.ad)); endproperty
   a_own: assert property (p_own) else $error("both drive data");
   property p_adr; $fell(pins.frame) |-> (&devDrv.oe.ad && &devDrv.oe.cbe)
      || (&farDrv.oe.ad && &farDrv.oe.cbe); endproperty
   a_adr: assert property (p_adr) else $error("address undriven");
   property p_frm; $fell(pins.frame) |-> !pins.frame[*6] ##[1:3] pins.frame; endproperty
   a_frm: assert property (p_frm) else $error("frame length");
   property p_rdy; $rose(pins.frame) |-> !pins.irdy[*6]; endproperty
   a_rdy: assert property (p_rdy) else $error("ready missing");
   property p_sel; $fell(pins.devsel) |-> pins.frame && !pins.irdy; endproperty
   a_sel: assert property (p_sel) else $error("stray decode");
   property p_gnt; $fell(pins.gnt[0]) |-> !pins.req[0]; endproperty
   a_gnt: assert property (p_gnt) else $error("grant unasked");
   property p_err; $fell(pins.perr) |-> !pins.perr[*6] ##[1:3] pins.perr; endproperty
   a_err: assert property (p_err) else $error("error length");
endmodule : pci_bus_checker

// ### tb/tb_top.sv
// Bench joining the device end and the far end of the bus.
`timescale 1ns/1ps
module tb_top;
   import pci_bus_pkg::*;
   logic ref_clk, sys_rst, busClock, dStart, fStart, fLock, eeCs, cfgSel, lkSeen;
   logic dDone, dAbort, dLock, dCfg, fDone, fAbort, fEe;
   logic [31:0] mAddr, mWd, dRx, fRx, dTAd;
   logic [3:0] mCmd, mBe, dTBe;
   logic [1:0] got;
   arbMode_t mode;
   int err_total, cmp_count;
   pci_link pci_link_inst (.busClock(busClock));
   pci_bus_pin_signalling pci_bus_pin_signalling_inst (.ref_clk, .sys_rst,
      .link(pci_link_inst), .arbMode(mode), .mstStart(dStart), .mstAddr(mAddr),
      .mstCmd(mCmd), .mstByteEnL(mBe), .mstWdata(mWd), .mstBusy(), .mstDone(dDone),
      .mstAbort(dAbort), .tgtRdata(32'h2468_ACE0), .tgtWrite(), .tgtAddr(dTAd),
      .tgtByteEnL(dTBe), .rxData(dRx), .perrSeen(), .lockActive(dLock),
      .configSel(dCfg), .eepromChipSelect(eeCs));
   pci_bus_far_agent pci_bus_far_agent_inst (.ref_clk, .sys_rst, .link(pci_link_inst),
      .arbMode(mode), .mstStart(fStart), .mstLock(fLock), .mstAddr(mAddr), .mstCmd(mCmd),
      .mstByteEnL(mBe), .mstWdata(mWd), .mstBusy(), .mstDone(fDone), .mstAbort(fAbort),
      .tgtRdata(32'h1357_9BDF), .tgtWrite(), .rxData(fRx), .perrSeen(),
      .configSelect(cfgSel), .eepromSelSeen(fEe));
   pci_bus_checker pci_bus_checker_inst (.ref_clk, .sys_rst, .devDrv(pci_link_inst.devDrv),
      .farDrv(pci_link_inst.farDrv), .pins(pci_link_inst.pins));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // The link clock starts off phase so its edges never line up with the core clock.
   initial begin
      busClock = 1'b0;
      #7;
      forever #160 busClock = ~busClock;
   end
   always @(posedge ref_clk) lkSeen <= !sys_rst && (lkSeen || dLock === 1'b1);
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [33:0] a, input logic [33:0] e);
      cmp_count++;
      if (a !== e) begin
         err_total++;
         $display("wrong value at %0t: got %h want %h", $time, a, e);
      end
   endtask : chk
   task automatic go(input logic far, input logic [31:0] a, input logic [3:0] c,
                     input logic [31:0] wd, input logic lk);
      @(posedge ref_clk);
      {mAddr, mCmd, mWd, fLock, dStart, fStart} <= {a, c, wd, lk, !far, far};
      @(posedge ref_clk);
      {dStart, fStart} <= 2'b00;
      got = 2'b00;
      for (int n = 0; n < 400 && got == 2'b00; n++) begin
         @(negedge ref_clk);
         got = far ? {fAbort, fDone} : {dAbort, dDone};
      end
      if (got == 2'b00) begin
         err_total++;
         give_verdict();
      end else begin
         // Lets the bus settle back to idle before the next request.
         repeat (60) @(posedge ref_clk);
      end
   endtask : go
   initial begin
      {sys_rst, dStart, fStart, fLock, eeCs, cfgSel} = 6'h20;
      {mAddr, mWd, mCmd, mBe} = '0;
      mode = ARB_INTERNAL;
      for (int m = 0; m < 3; m++) begin
         @(posedge ref_clk);
         {sys_rst, mode, mBe, eeCs, cfgSel} <= {1'b1, arbMode_t'(m[1:0]), 2'b00, m[1:0], 2'b00};
         repeat (12) @(posedge ref_clk);
         sys_rst <= 1'b0;
         repeat (20) @(posedge ref_clk);
         go(1'b0, 32'h2000_0010, 4'h7, 32'hA5A5_0F0F, 1'b0);
         chk({got, fRx}, {2'b01, 32'hA5A5_0F0F});
         go(1'b0, 32'h2000_0020, 4'h6, 32'h0, 1'b0);
         chk({got, dRx}, {2'b01, 32'h1357_9BDF});
         chk({33'h0, lkSeen}, 34'h0);
         go(1'b1, 32'h1000_0004, 4'h7, 32'h0F0F_A5A5, 1'b1);
         chk({got, dRx}, {2'b01, 32'h0F0F_A5A5});
         chk({dTBe[1:0], dTAd}, {mBe[1:0], 32'h1000_0004});
         chk({33'h0, lkSeen}, 34'h1);
         go(1'b1, 32'h1000_0008, 4'h6, 32'h0, 1'b0);
         chk({got, fRx}, {2'b01, 32'h2468_ACE0});
         go(1'b0, 32'h3000_0000, 4'h7, 32'h0, 1'b0);
         chk({got, 32'h0}, {2'b10, 32'h0});
         chk({32'h0, fEe, dCfg}, 34'h0);
         {eeCs, cfgSel} <= {2{m == 2}};
         repeat (40) @(negedge ref_clk);
         chk({32'h0, m == 2 ? {fEe, dCfg} : {pci_link_inst.pins.req[1],
             pci_link_inst.devDrv.oe.gnt[1] & pci_link_inst.devDrv.val.gnt[1]}},
             34'h3);
         go(1'b1, 32'h0000_0040, 4'hA, 32'h0, 1'b0);
         chk({got, fRx}, {(m == 2) ? 2'b01 : 2'b10, 32'h2468_ACE0});
         $display("mode %0d tests finished", m);
      end
      give_verdict();
   end
endmodule : tb_top
